// File: pch_cfg.sv
// Upper configuration header registers with master latency timer
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: Latency timer counts while driving frame
// RULE2: Early frame release ignores the timer
// RULE3: Expired and grant removed: terminate burst
// RULE4: Latency timer read-write, resets to zero
// RULE5: Header type and self test read zero
// RULE6: IO base bits 31-8 store address
// RULE7: IO base bits 7-2 read zero
// RULE8: IO bit0 reads one, bit1 reserved
// RULE9: Memory base bits 31-8 store address
// RULE10: Memory base bits 7-4 read zero
// RULE11: Memory base bits 3-0 read zero
// RULE12: Software programs memory base before use
// RULE13: Subsystem IDs from EEPROM, else defaults
// RULE14: Size zero: ROM enable reads zero
// RULE15: Size codes set writable ROM bits
// RULE16: BIOS sets ROM enable to decode
// RULE17: Interrupt line eight-bit read-write
// RULE18: Interrupt pin reads INTA code
// RULE19: Minimum grant from EEPROM, default 20h
// RULE20: Maximum latency from EEPROM, default 20h
// RULE21: Reserved bits read zero, ignore writes
module pch_cfg
	import pch_pkg::*;
#(
	parameter logic [15:0] SUBSYS_VENDOR_DEF = 16'h1234, // Arbitrary value
	parameter logic [15:0] SUBSYS_IDENT_DEF = 16'h5678 // Arbitrary value
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic cfg_rd_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic [2:0] rom_size_select_i,
	input wire logic eeprom_valid_i,
	input wire logic [15:0] ee_subsys_vendor_i,
	input wire logic [15:0] ee_subsys_ident_i,
	input wire logic [7:0] ee_min_grant_i,
	input wire logic [7:0] ee_max_latency_i,
	input wire logic frame_drive_i,
	input wire logic gnt_n_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_ack_o,
	output logic [31:0] io_base_o,
	output logic [31:0] mem_base_o,
	output logic [31:0] rom_base_o,
	output logic [7:0] irq_line_o,
	output logic lat_expired_o,
	output logic master_stop_o
);
	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] latency_timer_reg_q;
	logic [23:0] io_base_q;
	logic [23:0] mem_base_q;
	logic [ROM_MSB:ROM_LSB] rom_hi_q;
	logic [31:ROM_MSB+1] rom_top_q;
	logic rom_decode_enable_q;
	logic [7:0] irq_line_reg_q;
	logic [15:0] subsys_vendor_reg_q;
	logic [15:0] subsys_ident_reg_q;
	logic [7:0] min_grant_reg_q;
	logic [7:0] max_latency_reg_q;
	logic [7:0] lat_cnt_q;
	logic lat_run_q;
	logic [ROM_MSB:ROM_LSB] rom_wmask;
	logic rom_present;
	logic [31:0] io_word;
	logic [31:0] mem_word;
	logic [31:0] rom_word;
	logic [31:0] rd_word;
	logic [31:0] wmask;

	// Byte enables to bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{cfg_be_i[i]}};
		end
	end

	// ROM size boundary: bits below 12+size read zero
	always_comb begin
		rom_present = (rom_size_select_i != ROM_SIZE_NONE) && (rom_size_select_i <= ROM_SIZE_MAX); // RULE14
		for (int b = ROM_LSB; b <= ROM_MSB; b++) begin
			rom_wmask[b] = rom_present && (b >= ROM_LSB + 1 + int'(rom_size_select_i)); // RULE15
		end
	end

	// ****************************************
	// Writable registers
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			latency_timer_reg_q <= LAT_RST; // RULE4
		end else if (cfg_wr_i && cfg_addr_i == OFS_SELF_TEST_REG_HDR_LAT && cfg_be_i[1]) begin
			latency_timer_reg_q <= cfg_wdata_i[LAT_LSB +: 8]; // RULE4
		end
	end

	// Header type and self test bytes have no storage, writes dropped
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			io_base_q <= '0;
			mem_base_q <= '0;
		end else if (cfg_wr_i) begin
			if (cfg_addr_i == OFS_IO_BASE) begin
				io_base_q <= (io_base_q & ~wmask[31:8]) | (cfg_wdata_i[31:8] & wmask[31:8]); // RULE6
			end
			if (cfg_addr_i == OFS_MEM_BASE) begin
				mem_base_q <= (mem_base_q & ~wmask[31:8]) | (cfg_wdata_i[31:8] & wmask[31:8]); // RULE9
			end
		end
	end

	// Boot ROM base; masked by strap on write and on read, but bits stored under an earlier strap stay and can re-appear after a strap change
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rom_top_q <= '0;
			rom_hi_q <= '0;
			rom_decode_enable_q <= 1'b0;
		end else if (cfg_wr_i && cfg_addr_i == OFS_ROM_BASE) begin
			rom_top_q <= (rom_top_q & ~wmask[31:ROM_MSB+1])
				| (cfg_wdata_i[31:ROM_MSB+1] & wmask[31:ROM_MSB+1]);
			rom_hi_q <= (rom_hi_q & ~(wmask[ROM_MSB:ROM_LSB] & rom_wmask))
				| (cfg_wdata_i[ROM_MSB:ROM_LSB] & wmask[ROM_MSB:ROM_LSB] & rom_wmask); // RULE15
			if (cfg_be_i[0]) begin
				rom_decode_enable_q <= cfg_wdata_i[0] & rom_present; // RULE14
			end
		end
	end

	// Interrupt line
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			irq_line_reg_q <= IRQ_LINE_RST;
		end else if (cfg_wr_i && cfg_addr_i == OFS_IRQ && cfg_be_i[0]) begin
			irq_line_reg_q <= cfg_wdata_i[7:0]; // RULE17
		end
	end

	// ****************************************
	// EEPROM-loaded read-only values
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			subsys_vendor_reg_q <= '0;
			subsys_ident_reg_q <= '0;
			min_grant_reg_q <= MIN_GNT_DEF;
			max_latency_reg_q <= MAX_LAT_DEF;
		end else begin
			subsys_vendor_reg_q <= eeprom_valid_i ? ee_subsys_vendor_i : SUBSYS_VENDOR_DEF; // RULE13
			subsys_ident_reg_q <= eeprom_valid_i ? ee_subsys_ident_i : SUBSYS_IDENT_DEF; // RULE13
			min_grant_reg_q <= eeprom_valid_i ? ee_min_grant_i : MIN_GNT_DEF; // RULE19
			max_latency_reg_q <= eeprom_valid_i ? ee_max_latency_i : MAX_LAT_DEF; // RULE20
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		io_word = {io_base_q, 6'h00, 1'b0, IO_SPACE_FLAG}; // RULE7 RULE8
		mem_word = {mem_base_q, 4'h0, 1'b0, 2'h0, 1'b0}; // RULE10 RULE11
		rom_word = {rom_top_q, rom_hi_q & rom_wmask, 10'h000, rom_decode_enable_q & rom_present};
		unique case (cfg_addr_i)
			OFS_SELF_TEST_REG_HDR_LAT: rd_word = {16'h0000, latency_timer_reg_q, 8'h00}; // RULE5
			OFS_IO_BASE: rd_word = io_word;
			OFS_MEM_BASE: rd_word = mem_word;
			OFS_SUBSYS: rd_word = {subsys_ident_reg_q, subsys_vendor_reg_q};
			OFS_ROM_BASE: rd_word = rom_word;
			OFS_IRQ: rd_word = {max_latency_reg_q, min_grant_reg_q, IRQ_PIN_VAL, irq_line_reg_q}; // RULE18
			default: rd_word = 32'h0000_0000; // RULE21
		endcase
	end

	// Registered answer, one cycle after request
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cfg_rdata_o <= '0;
			cfg_ack_o <= 1'b0;
		end else begin
			cfg_ack_o <= cfg_rd_i | cfg_wr_i;
			cfg_rdata_o <= cfg_rd_i ? rd_word : 32'h0000_0000;
		end
	end

	// Decoder views for the operational address decode
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			io_base_o <= '0;
			mem_base_o <= '0;
			rom_base_o <= '0;
			irq_line_o <= '0;
		end else begin
			io_base_o <= io_word;
			mem_base_o <= mem_word; // RULE12
			rom_base_o <= rom_word; // RULE16
			irq_line_o <= irq_line_reg_q;
		end
	end

	// ****************************************
	// Master latency timer
	// ****************************************
	// Counts up from frame start; a new frame restarts it
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			lat_cnt_q <= '0;
			lat_run_q <= 1'b0;
		end else if (!frame_drive_i) begin
			lat_cnt_q <= '0; // RULE2
			lat_run_q <= 1'b0;
		end else begin
			lat_run_q <= 1'b1; // RULE1
			if (lat_cnt_q != latency_timer_reg_q) begin
				lat_cnt_q <= lat_cnt_q + 8'h01; // RULE1
			end
		end
	end

	// Expiry flag and stop request; stop only once grant has gone
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			lat_expired_o <= 1'b0;
			master_stop_o <= 1'b0;
		end else begin
			lat_expired_o <= frame_drive_i && lat_run_q && (lat_cnt_q == latency_timer_reg_q);
			master_stop_o <= frame_drive_i && lat_run_q && (lat_cnt_q == latency_timer_reg_q)
				&& gnt_n_i; // RULE3
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Most checks look one edge past a request, since the answer is registered;
	// all but AST_LAT_RST are idle while reset is held.

	// Timer register cleared by reset
	AST_LAT_RST: assert property (@(posedge sys_clk_i) // RULE4
		rst_i |=> latency_timer_reg_q == LAT_RST)
		else $error("latency timer not zero after reset");

	// Stop only follows a removed grant during a frame
	AST_STOP_GNT: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
		master_stop_o |-> $past(gnt_n_i) && $past(frame_drive_i))
		else $error("stop without grant removed");

	// Released frame clears the timer outputs
	AST_NO_FRAME_NO_STOP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
		!frame_drive_i |=> !master_stop_o && !lat_expired_o)
		else $error("timer acted after frame released");

	// Count advances every frame cycle until it meets the limit
	AST_CNT_RUN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
		frame_drive_i && lat_cnt_q != latency_timer_reg_q |=> lat_cnt_q == $past(lat_cnt_q) + 8'h01
		|| $past(cfg_wr_i))
		else $error("latency count stalled");

	// Expiry only ever seen inside a frame
	AST_EXP_FRAME: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
		lat_expired_o |-> $past(frame_drive_i))
		else $error("expiry outside a frame");

	// A stop request always comes with expiry
	AST_STOP_EXP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
		master_stop_o |-> lat_expired_o)
		else $error("stop before expiry");

	// Timer register takes byte one of a write
	AST_LAT_WR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
		cfg_wr_i && cfg_addr_i == OFS_SELF_TEST_REG_HDR_LAT && cfg_be_i[1]
		|=> latency_timer_reg_q == $past(cfg_wdata_i[LAT_LSB +: 8]))
		else $error("latency timer write lost");

	// Timer register reads back what it holds
	AST_LAT_RD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
		cfg_rd_i && cfg_addr_i == OFS_SELF_TEST_REG_HDR_LAT |=> cfg_rdata_o[15:8] == $past(latency_timer_reg_q))
		else $error("latency timer readback wrong");

	// Header type and self test bytes stay zero
	AST_HDR_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE5
		cfg_rd_i && cfg_addr_i == OFS_SELF_TEST_REG_HDR_LAT |=> cfg_rdata_o[31:16] == 16'h0000)
		else $error("header type or self test nonzero");

	// Full IO base write lands in the upper bits
	AST_IO_WR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
		cfg_wr_i && cfg_addr_i == OFS_IO_BASE && cfg_be_i == 4'hf
		|=> io_base_q == $past(cfg_wdata_i[31:BASE_LSB]))
		else $error("io base write lost");

	// IO base holds while not addressed
	AST_IO_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
		!(cfg_wr_i && cfg_addr_i == OFS_IO_BASE) |=> $stable(io_base_q))
		else $error("io base changed without a write");

	// Size bits zero, space flag one
	AST_IO_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
		cfg_rd_i && cfg_addr_i == OFS_IO_BASE |=> cfg_rdata_o[7:0] == 8'h01)
		else $error("io base low bits wrong");

	// Full memory base write lands in the upper bits
	AST_MEM_WR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE9
		cfg_wr_i && cfg_addr_i == OFS_MEM_BASE && cfg_be_i == 4'hf
		|=> mem_base_q == $past(cfg_wdata_i[31:BASE_LSB]))
		else $error("mem base write lost");

	// Memory base holds while not addressed
	AST_MEM_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE9
		!(cfg_wr_i && cfg_addr_i == OFS_MEM_BASE) |=> $stable(mem_base_q))
		else $error("mem base changed without a write");

	// Memory window size bits read zero
	AST_MEM_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE10
		cfg_rd_i && cfg_addr_i == OFS_MEM_BASE |=> cfg_rdata_o[7:0] == 8'h00)
		else $error("mem base low bits wrong");

	// Prefetch, location and space flags read zero
	AST_MEM_FLAGS: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE11
		cfg_rd_i && cfg_addr_i == OFS_MEM_BASE |=> cfg_rdata_o[3:0] == 4'h0)
		else $error("mem base flags nonzero");

	// Subsystem codes fall back to built-in values
	AST_SUBSYS_DEF: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
		!eeprom_valid_i |=> subsys_vendor_reg_q == SUBSYS_VENDOR_DEF && subsys_ident_reg_q == SUBSYS_IDENT_DEF)
		else $error("subsystem default wrong");

	// Subsystem vendor code follows the loaded value
	AST_SUBSYS_EE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
		eeprom_valid_i |=> subsys_vendor_reg_q == $past(ee_subsys_vendor_i))
		else $error("subsystem vendor not loaded");

	// No ROM strap means nothing writable
	AST_NO_ROM: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE14
		rom_size_select_i == ROM_SIZE_NONE |-> rom_wmask == '0)
		else $error("rom bits writable without rom");

	// No ROM means the decode enable reads zero
	AST_ROM_EN_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE14
		cfg_rd_i && cfg_addr_i == OFS_ROM_BASE && !rom_present |=> cfg_rdata_o[0] == 1'b0)
		else $error("rom enable set without rom");

	// Smallest ROM hides bits 12-11
	AST_ROM_SMALL: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE15
		cfg_rd_i && cfg_addr_i == OFS_ROM_BASE && rom_size_select_i == 3'h1 |=> cfg_rdata_o[12:11] == 2'b00)
		else $error("rom size bits wrong for smallest rom");

	// Largest ROM hides bits 16-11
	AST_ROM_LARGE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE15
		cfg_rd_i && cfg_addr_i == OFS_ROM_BASE && rom_size_select_i == ROM_SIZE_MAX
		|=> cfg_rdata_o[16:11] == 6'h00)
		else $error("rom size bits wrong for largest rom");

	// Interrupt line takes byte zero of a write
	AST_IRQ_WR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE17
		cfg_wr_i && cfg_addr_i == OFS_IRQ && cfg_be_i[0] |=> irq_line_reg_q == $past(cfg_wdata_i[7:0]))
		else $error("interrupt line write lost");

	// Pin byte always names the first interrupt pin
	AST_PIN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE18
		cfg_rd_i && cfg_addr_i == OFS_IRQ |=> cfg_rdata_o[15:8] == 8'h01)
		else $error("interrupt pin wrong");

	// Grant and latency defaults without EEPROM
	AST_GNT_DEF: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE19
		!eeprom_valid_i |=> min_grant_reg_q == 8'h20 && max_latency_reg_q == 8'h20)
		else $error("grant or latency default wrong");

	// Maximum latency follows the loaded value
	AST_MAXLAT_EE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE20
		eeprom_valid_i |=> max_latency_reg_q == $past(ee_max_latency_i))
		else $error("maximum latency not loaded");

	// Reserved ROM base bits 10-1 read zero
	AST_ROM_RSVD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE21
		cfg_rd_i && cfg_addr_i == OFS_ROM_BASE |=> cfg_rdata_o[10:1] == 10'h000)
		else $error("reserved rom bits nonzero");
endmodule // pch_cfg
`default_nettype wire

// File: pch_pkg.sv
// Package: configuration header offsets, field layouts and reset values
package pch_pkg;
	// ****************************************
	// Configuration dword offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_SELF_TEST_REG_HDR_LAT = 8'h0c;
	localparam logic [7:0] OFS_IO_BASE = 8'h10;
	localparam logic [7:0] OFS_MEM_BASE = 8'h14;
	localparam logic [7:0] OFS_SUBSYS = 8'h2c;
	localparam logic [7:0] OFS_ROM_BASE = 8'h30;
	localparam logic [7:0] OFS_IRQ = 8'h3c;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int BASE_LSB = 8;
	localparam int ROM_LSB = 11;
	localparam int ROM_MSB = 17;
	localparam int LAT_LSB = 8;
	localparam int IRQ_PIN_LSB = 8;
	localparam int MIN_GNT_LSB = 16;
	localparam int MAX_LAT_LSB = 24;
	localparam logic [7:0] LAT_RST = 8'h00;
	localparam logic [7:0] IRQ_LINE_RST = 8'h00;
	localparam logic [7:0] IRQ_PIN_VAL = 8'h01;
	localparam logic [7:0] MIN_GNT_DEF = 8'h20;
	localparam logic [7:0] MAX_LAT_DEF = 8'h20;
	localparam logic IO_SPACE_FLAG = 1'b1;
	localparam logic [2:0] ROM_SIZE_NONE = 3'h0;
	localparam logic [2:0] ROM_SIZE_MAX = 3'h5;
endpackage

// File: pch_host.sv
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module pch_host (
	input wire logic sys_clk_i,
	input wire logic cfg_ack_i,
	input wire logic [31:0] cfg_rdata_i,
	output logic cfg_rd_o,
	output logic cfg_wr_o,
	output logic [7:0] cfg_addr_o,
	output logic [3:0] cfg_be_o,
	output logic [31:0] cfg_wdata_o
);
	// Idle lines start low
	initial begin
		cfg_rd_o = 1'b0;
		cfg_wr_o = 1'b0;
		cfg_addr_o = 8'h00;
		cfg_be_o = 4'h0;
		cfg_wdata_o = 32'h0;
	end
	// One-edge pulse; answer taken a cycle later
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] q, output logic k);
		@(negedge sys_clk_i);
		cfg_rd_o = !w;
		cfg_wr_o = w;
		cfg_addr_o = a;
		cfg_be_o = b;
		cfg_wdata_o = d;
		@(negedge sys_clk_i);
		cfg_rd_o = 1'b0;
		cfg_wr_o = 1'b0;
		// Released lines flip so stale values never match
		cfg_addr_o = ~a;
		cfg_be_o = ~b;
		cfg_wdata_o = ~d;
		q = cfg_rdata_i;
		k = cfg_ack_i;
	endtask
endmodule // pch_host
`default_nettype wire

// File: pci_config_header_upper_test.sv
// Self-checking bench for the upper configuration header
`timescale 1ns/1ps
`default_nettype none
module pci_config_header_upper_test;
	import pch_pkg::*;
	localparam logic [15:0] SV = 16'h4a51; // Arbitrary value
	localparam logic [15:0] SI = 16'h0b3c; // Arbitrary value
	localparam logic [31:0] ALL = 32'hffffffff;
	logic sys_clk_i, rst_i, rd, wr, ack, ee_ok, frame, gnt_n, lat_exp, mstop;
	logic [7:0] addr, irq_line;
	logic [3:0] be;
	logic [2:0] rom_sel;
	logic [31:0] wdata, rdata, io_b, mem_b, rom_b;
	int n_fail = 0;
	int total_checks = 0;
	pch_host i_host (.sys_clk_i(sys_clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata),
		.cfg_rd_o(rd), .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata));
	pch_cfg #(.SUBSYS_VENDOR_DEF(SV), .SUBSYS_IDENT_DEF(SI)) i_dut (.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be),
		.cfg_wdata_i(wdata), .rom_size_select_i(rom_sel), .eeprom_valid_i(ee_ok),
		.ee_subsys_vendor_i(16'h2468), .ee_subsys_ident_i(16'h1357),
		.ee_min_grant_i(8'h11), .ee_max_latency_i(8'h44), .frame_drive_i(frame),
		.gnt_n_i(gnt_n), .cfg_rdata_o(rdata), .cfg_ack_o(ack), .io_base_o(io_b),
		.mem_base_o(mem_b), .rom_base_o(rom_b), .irq_line_o(irq_line),
		.lat_expired_o(lat_exp), .master_stop_o(mstop));
	// 125 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	// Access with ack check; writes answer zero data
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		logic k;
		i_host.xfer(w, a, b, d, q, k);
		check({31'h0, k}, 32'h1);
		check(q & m, e);
	endtask
	task automatic wrt(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		acc(1'b1, a, b, d, ALL, 32'h0);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		acc(1'b0, a, 4'hf, 32'h0, m, e);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rdc(OFS_SELF_TEST_REG_HDR_LAT, 32'hffffff00, 32'h0);
		rdc(OFS_IO_BASE, ALL, 32'h1);
		rdc(OFS_MEM_BASE, ALL, 32'h0);
		rdc(OFS_SUBSYS, ALL, {SI, SV});
		rdc(OFS_IRQ, ALL, 32'h20200100);
	endtask
	// Read-only bits must shrug off all-ones writes
	task automatic t_writes;
		wrt(OFS_SELF_TEST_REG_HDR_LAT, 4'hf, ALL);
		rdc(OFS_SELF_TEST_REG_HDR_LAT, 32'hffffff00, 32'h0000ff00);
		wrt(OFS_IO_BASE, 4'hf, ALL);
		rdc(OFS_IO_BASE, ALL, 32'hffffff01);
		wrt(OFS_IO_BASE, 4'h4, 32'h0);
		rdc(OFS_IO_BASE, ALL, 32'hff00ff01);
		check(io_b, 32'hff00ff01);
		wrt(OFS_MEM_BASE, 4'hf, ALL);
		rdc(OFS_MEM_BASE, ALL, 32'hffffff00);
		check(mem_b, 32'hffffff00);
		wrt(8'h18, 4'hf, ALL);
		rdc(8'h18, ALL, 32'h0);
		wrt(OFS_IRQ, 4'hf, ALL);
		rdc(OFS_IRQ, ALL, 32'h202001ff);
		wrt(OFS_IRQ, 4'h1, 32'h5a);
		// Line image is one flop behind the register
		@(negedge sys_clk_i);
		check({24'h0, irq_line}, 32'h5a);
	endtask
	// Every strap code, all-ones write then readback
	task automatic t_rom;
		logic [31:0] e;
		logic [31:0] m;
		for (int c = 0; c < 8; c++) begin
			rom_sel = 3'(c);
			m = (c >= 1 && c <= 5) ? ALL : 32'hfffc07ff;
			e = (c >= 1 && c <= 5) ? ((32'h3ffff << (12 + c)) & 32'h3ffff) | 32'h1 : 32'h0;
			wrt(OFS_ROM_BASE, 4'hf, ALL);
			rdc(OFS_ROM_BASE, m, e | 32'hfffc0000);
			check(rom_b & m, e | 32'hfffc0000);
		end
	endtask
	// Frame released before expiry leaves no trace
	task automatic t_lat_short;
		wrt(OFS_SELF_TEST_REG_HDR_LAT, 4'h2, 32'h300);
		gnt_n = 1'b1;
		frame = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		frame = 1'b0;
		repeat (6) @(negedge sys_clk_i);
		check({30'h0, lat_exp, mstop}, 32'h0);
	endtask
	// Expiry alone does not stop; grant removal does
	task automatic t_lat;
		gnt_n = 1'b0;
		frame = 1'b1;
		@(negedge sys_clk_i);
		check({30'h0, lat_exp, mstop}, 32'h0);
		repeat (6) @(negedge sys_clk_i);
		check({30'h0, lat_exp, mstop}, 32'h2);
		gnt_n = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		check({30'h0, lat_exp, mstop}, 32'h3);
		frame = 1'b0;
	endtask
	// Mid-run reset with EEPROM present
	task automatic t_eeprom;
		rst_i = 1'b1;
		ee_ok = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		rst_i = 1'b0;
		rdc(OFS_SELF_TEST_REG_HDR_LAT, 32'hffffff00, 32'h0);
		rdc(OFS_SUBSYS, ALL, 32'h13572468);
		rdc(OFS_IRQ, ALL, 32'h44110100);
	endtask
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_i = 1'b1;
		rom_sel = 3'h0;
		ee_ok = 1'b0;
		frame = 1'b0;
		gnt_n = 1'b1;
		repeat (8) @(negedge sys_clk_i);
		rst_i = 1'b0;
		t_reset;
		t_writes;
		t_rom;
		t_lat_short;
		t_lat;
		t_eeprom;
		end_sim;
	end
	// Watchdog well beyond the hundred or so cycles needed
	initial begin
		#20000;
		n_fail++;
		end_sim;
	end
endmodule // pci_config_header_upper_test
`default_nettype wire
